//--- rtl/bdr_bkpt_unit.sv
// Module: breakpoint comparator with tag and force handling
`timescale 1ns/1ps
module bdr_bkpt_unit
  import bdr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // CPU bus observation
  input  wire logic [ADDR_W-1:0] cpuAddr,
  input  wire logic              cpuAddrValid,
  input  wire logic              instrBoundary,
  input  wire logic              tagAtQueueEnd,
  // Tag mark toward the instruction queue
  output logic                   tagOpcode,
  // Configuration and break event
  bdr_link_if.bkpt               link
);

  // ==========================================================================
  // Match decode
  // ==========================================================================
  logic forcePending;  // Force match waiting for an instruction boundary
  wire  armed     = link.bkptEnable && !link.cpuActive;
  wire  addrHit   = armed && cpuAddrValid && (cpuAddr == link.bkptAddr);
  wire  forceHit  = addrHit && link.forceSelect;
  wire  tagHit    = addrHit && !link.forceSelect;
  // A tag only acts when the marked opcode reaches the end of the queue
  wire  tagFire   = armed && !link.forceSelect && tagAtQueueEnd;
  wire  forceFire = armed && link.forceSelect && instrBoundary && (forcePending || forceHit);

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Pending force is held until the boundary, any address need not be an opcode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      forcePending    <= RST_BIT;
      tagOpcode       <= RST_BIT;
      link.breakEvent <= RST_BIT;
    end else begin
      forcePending    <= armed && link.forceSelect && !instrBoundary && (forcePending || forceHit);
      tagOpcode       <= tagHit;
      link.breakEvent <= forceFire || tagFire;
    end
  end

endmodule : bdr_bkpt_unit

//--- rtl/bdr_cmd_decode.sv
// Module: decodes the serial command code into one-hot command strobes
`timescale 1ns/1ps
module bdr_cmd_decode
  import bdr_pkg::*;
(
  // Command from the serial engine
  input  wire logic             cmdValid,
  input  wire logic [CMD_W-1:0] cmdCode,
  // Decoded strobes
  bdr_link_if.decoder           link
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Unknown codes raise no strobe and are simply dropped
  assign link.rdStatus   = cmdValid && (cmdCode == CMD_READ_STATUS);
  assign link.wrControl  = cmdValid && (cmdCode == CMD_WRITE_CONTROL);
  assign link.rdBkpt     = cmdValid && (cmdCode == CMD_BREAKPOINT_READ_CMD);
  assign link.wrBkpt     = cmdValid && (cmdCode == CMD_BREAKPOINT_WRITE_CMD);
  assign link.background = cmdValid && (cmdCode == CMD_BACKGROUND);
  assign link.go         = cmdValid && (cmdCode == CMD_GO);
  assign link.rdByte     = cmdValid && (cmdCode == CMD_READ_BYTE);
  assign link.wrByte     = cmdValid && (cmdCode == CMD_WRITE_BYTE);

endmodule : bdr_cmd_decode

//--- rtl/bdr_debug_regs.sv
// Module: status/control, breakpoint and force-reset registers of the serial debug controller
`timescale 1ns/1ps
// Functional notes
// - enable bit gates entry to halt mode
// - enable stays set until normal reset
// - bit six reads active halt status
// - breakpoint enable off ignores match settings
// - force match halts at next boundary
// - tagged opcode halts at queue end
// - bit three selects comm clock, default alternate
// - bit two shows wait/stop status
// - background command leaves wait/stop for halt
// - bit one flags memory access wait/stop failure
// - data valid failure flag reads zero
// - status byte only via serial commands
// - breakpoint address is 16 bits, serial only
// - force-reset accepts serial writes, reads zero
// - writing force-reset bit resets the chip
// - enable bit locked while in halt mode
// - status flags read-only to control writes
// - breakpoint without enable runs software interrupt
module bdr_debug_regs
  import bdr_pkg::*;
#(
  parameter logic [bdr_pkg::ADDR_W-1:0] FORCE_RESET_ADDR = 16'h1800  // Memory address of force-reset byte
)(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // Serial command engine side
  input  wire logic                          cmdValid,
  input  wire logic [bdr_pkg::CMD_W-1:0]     cmdCode,
  input  wire logic [bdr_pkg::ADDR_W-1:0]    cmdAddr,
  input  wire logic [2*bdr_pkg::BYTE_W-1:0]  cmdData,
  output logic                               rspValid,
  output logic [2*bdr_pkg::BYTE_W-1:0]       rspData,
  // Debug memory access port
  output logic                               memRead,
  output logic                               memWrite,
  output logic [bdr_pkg::ADDR_W-1:0]         memAddr,
  output logic [bdr_pkg::BYTE_W-1:0]         memWData,
  input  wire logic [bdr_pkg::BYTE_W-1:0]    memRData,
  // CPU status and observation
  input  wire logic                          cpuWaitStop,
  input  wire logic [bdr_pkg::ADDR_W-1:0]    cpuAddr,
  input  wire logic                          cpuAddrValid,
  input  wire logic                          instrBoundary,
  input  wire logic                          tagAtQueueEnd,
  // CPU control
  output logic                               haltCpu,
  output logic                               tagOpcode,
  output logic                               swiRequest,
  output logic                               commClockSelect,
  output logic                               resetRequest
);
  import bdr_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  bdr_link_if link ();                 // Internal carrier
  bdr_mode_t  mode;                    // CPU mode tracker
  bdr_mode_t  next_mode;               // Next mode
  // Register bits
  logic       bgEnable;                // background_enable
  logic       bkptEnable;              // breakpoint_enable
  logic       forceSelect;             // tag_or_force_select
  logic       fromWaitStop;            // Halt was entered from wait/stop
  logic       waitStopFail;            // wait_stop_failure_flag
  logic [ADDR_W-1:0] bkptAddr;         // debug_breakpoint_address
  logic       memReadPend;             // Memory read data returns next cycle

  // ==========================================================================
  // Submodules
  // ==========================================================================
  bdr_cmd_decode u_decode (
    .cmdValid (cmdValid),
    .cmdCode  (cmdCode),
    .link     (link)
  );

  bdr_bkpt_unit u_bkpt (
    .clk           (clk),
    .nrst          (nrst),
    .cpuAddr       (cpuAddr),
    .cpuAddrValid  (cpuAddrValid),
    .instrBoundary (instrBoundary),
    .tagAtQueueEnd (tagAtQueueEnd),
    .tagOpcode     (tagOpcode),
    .link          (link)
  );

  // Configuration handed to the breakpoint unit
  assign link.bgEnable    = bgEnable;
  assign link.bkptEnable  = bkptEnable;
  assign link.forceSelect = forceSelect;
  assign link.bkptAddr    = bkptAddr;
  // Breakpoints rest while halted
  assign link.cpuActive   = (mode == MODE_ACTIVE);

  // ==========================================================================
  // Command qualification
  // ==========================================================================
  // Halt can only be entered when the enable bit is set
  wire isActive    = (mode == MODE_ACTIVE);
  wire isWaitStop  = (mode == MODE_WAITST);
  wire bgEntry     = link.background && bgEnable;
  wire breakHalt   = link.breakEvent && bgEnable;
  wire breakSwi    = link.breakEvent && !bgEnable;

  // Memory commands cannot complete while the CPU sits in wait/stop
  wire memCmd      = link.rdByte || link.wrByte;
  wire memFail     = memCmd && isWaitStop;
  wire memOk       = memCmd && !isWaitStop;

  wire hitForceRst = (cmdAddr == FORCE_RESET_ADDR);
  // Only the serial write path reaches the force-reset byte; there is no user bus port
  wire forceRstWr  = link.wrByte && !isWaitStop && hitForceRst;
  wire forceRstRd  = link.rdByte && !isWaitStop && hitForceRst;

  wire plainWr     = memOk && link.wrByte && !hitForceRst;
  wire plainRd     = memOk && link.rdByte && !hitForceRst;

  // Status byte as returned to the host; bit 0 has no slow memory to report
  wire [BYTE_W-1:0] statusByte = {bgEnable, isActive, bkptEnable, forceSelect,
                                  commClockSelect, isWaitStop || (isActive && fromWaitStop),
                                  waitStopFail, RST_BIT};

  // ==========================================================================
  // Mode tracker
  // ==========================================================================
  // Background entry wins over a wakeup in the same cycle; breakpoint halt acts only from run
  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_RUN: begin
        if (bgEntry || breakHalt) begin
          next_mode = MODE_ACTIVE;
        end else if (cpuWaitStop) begin
          next_mode = MODE_WAITST;
        end
      end

      MODE_WAITST: begin
        if (bgEntry) begin
          next_mode = MODE_ACTIVE;
        end else if (!cpuWaitStop) begin
          next_mode = MODE_RUN;
        end
      end

      // Only GO leaves halt
      MODE_ACTIVE: begin
        if (link.go) begin
          next_mode = MODE_RUN;
        end
      end
      default: begin
        next_mode = MODE_RUN;
      end
    endcase
  end

  // Mode register and halt line; halt follows the mode so it sits on a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode    <= MODE_RUN;
      haltCpu <= RST_BIT;
    end else begin
      mode    <= next_mode;
      haltCpu <= (next_mode == MODE_ACTIVE);
    end
  end

  // Remembers that halt was reached out of wait/stop, dropped on resume
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fromWaitStop <= RST_BIT;
    end else if (isWaitStop && bgEntry) begin
      fromWaitStop <= 1'b1;
    end else if (next_mode != MODE_ACTIVE) begin
      fromWaitStop <= RST_BIT;
    end
  end

  // ==========================================================================
  // Status/control byte
  // ==========================================================================
  // Enable can only be set by the host and never cleared short of reset;
  // the lock in halt mode avoids forbidding a mode already in force
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bgEnable <= RST_BIT;
    end else if (link.wrControl && !isActive && cmdData[BIT_BG_ENABLE]) begin
      bgEnable <= 1'b1;
    end
  end

  // Writable controls; status flags are not touched by control writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bkptEnable      <= RST_BIT;
      forceSelect     <= RST_BIT;
      commClockSelect <= RST_BIT;
    end else if (link.wrControl) begin
      bkptEnable      <= cmdData[BIT_BKPT_EN];
      forceSelect     <= cmdData[BIT_TAG_FORCE];
      commClockSelect <= cmdData[BIT_CLK_SEL];
    end
  end

  // Failure flag: set on a blocked access, cleared by the next good one.
  // A failure in the same cycle keeps the flag set.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitStopFail <= RST_BIT;
    end else if (memFail) begin
      waitStopFail <= 1'b1;
    end else if (memOk) begin
      waitStopFail <= RST_BIT;
    end
  end

  // ==========================================================================
  // Breakpoint match register
  // ==========================================================================
  // Full 16-bit word, reached only by the dedicated serial commands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bkptAddr <= RST_BKPT;
    end else if (link.wrBkpt) begin
      bkptAddr <= cmdData;
    end
  end

  // ==========================================================================
  // Force reset and software interrupt
  // ==========================================================================
  // No storage: a one-cycle pulse, so the bit can never read back as one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resetRequest <= RST_BIT;
      swiRequest   <= RST_BIT;
    end else begin
      resetRequest <= forceRstWr && cmdData[BIT_FORCE_RST];
      swiRequest   <= breakSwi;
    end
  end

  // ==========================================================================
  // Memory access port
  // ==========================================================================
  // Strobes last one cycle; address and data hold until the next access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      memRead     <= RST_BIT;
      memWrite    <= RST_BIT;
      memReadPend <= RST_BIT;
      memAddr     <= RST_BKPT;
      memWData    <= RST_BYTE;
    end else begin
      memRead     <= plainRd;
      memWrite    <= plainWr;
      memReadPend <= plainRd;
      if (plainRd || plainWr) begin
        memAddr  <= cmdAddr;
        memWData <= cmdData[BYTE_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Responses
  // ==========================================================================
  // Status, breakpoint and force-reset reads answer in one cycle, other memory reads in two;
  // the status byte is only ever returned here, never from the memory map
  // Memory answer lost if a status read meets it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rspValid <= RST_BIT;
      rspData  <= READ_ZERO;
    end else if (link.rdStatus) begin
      rspValid <= 1'b1;
      rspData  <= {RST_BYTE, statusByte};
    end else if (link.rdBkpt) begin
      rspValid <= 1'b1;
      rspData  <= bkptAddr;
    end else if (forceRstRd) begin
      rspValid <= 1'b1;
      rspData  <= READ_ZERO;
    end else if (memReadPend) begin
      rspValid <= 1'b1;
      rspData  <= {RST_BYTE, memRData};
    end else begin
      rspValid <= RST_BIT;
    end
  end

endmodule : bdr_debug_regs

//--- rtl/bdr_link_if.sv
// Interface: internal carrier between command decoder, breakpoint unit and register core
`timescale 1ns/1ps
interface bdr_link_if;
  import bdr_pkg::*;

  // Decoded one-cycle command strobes
  logic              rdStatus;
  logic              wrControl;
  logic              rdBkpt;
  logic              wrBkpt;
  logic              background;
  logic              go;
  logic              rdByte;
  logic              wrByte;
  // Breakpoint configuration from the register core
  logic              bgEnable;
  logic              bkptEnable;
  logic              forceSelect;
  logic [ADDR_W-1:0] bkptAddr;
  logic              cpuActive;
  // Breakpoint event back to the core
  logic              breakEvent;

  modport decoder (output rdStatus, wrControl, rdBkpt, wrBkpt, background, go, rdByte, wrByte);
  modport bkpt    (input bgEnable, bkptEnable, forceSelect, bkptAddr, cpuActive, output breakEvent);
  modport core    (input rdStatus, wrControl, rdBkpt, wrBkpt, background, go, rdByte, wrByte, breakEvent,
                   output bgEnable, bkptEnable, forceSelect, bkptAddr, cpuActive);
endinterface : bdr_link_if

//--- rtl/bdr_pkg.sv
// Package: shared constants, command codes and state type of the debug register block
package bdr_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int ADDR_W = 16;   // CPU address and breakpoint match width
  localparam int BYTE_W = 8;    // Status/control and memory data width
  localparam int CMD_W  = 4;    // Serial command code width

  // ==========================================================================
  // Status/control byte field positions
  // ==========================================================================
  localparam int BIT_BG_ENABLE = 7;  // background_enable
  localparam int BIT_ACTIVE    = 6;  // background_active_flag
  localparam int BIT_BKPT_EN   = 5;  // breakpoint_enable
  localparam int BIT_TAG_FORCE = 4;  // tag_or_force_select
  localparam int BIT_CLK_SEL   = 3;  // comm_clock_select
  localparam int BIT_WAIT_STOP = 2;  // wait_stop_flag
  localparam int BIT_WS_FAIL   = 1;  // wait_stop_failure_flag
  localparam int BIT_DV_FAIL   = 0;  // data_valid_failure_flag
  localparam int BIT_FORCE_RST = 0;  // force_reset_bit in debug_force_reset

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic                RST_BIT   = 1'b0;
  localparam logic [BYTE_W-1:0]   RST_BYTE  = 8'h00;
  localparam logic [ADDR_W-1:0]   RST_BKPT  = 16'h0000;
  localparam logic [2*BYTE_W-1:0] READ_ZERO = 16'h0000;  // Value of every force-reset read

  // ==========================================================================
  // Serial command codes (arbitrary encoding of the command engine)
  // ==========================================================================
  localparam logic [CMD_W-1:0] CMD_READ_STATUS   = 4'h1;
  localparam logic [CMD_W-1:0] CMD_WRITE_CONTROL = 4'h2;
  localparam logic [CMD_W-1:0] CMD_BREAKPOINT_READ_CMD     = 4'h3;
  localparam logic [CMD_W-1:0] CMD_BREAKPOINT_WRITE_CMD    = 4'h4;
  localparam logic [CMD_W-1:0] CMD_BACKGROUND    = 4'h5;
  localparam logic [CMD_W-1:0] CMD_GO            = 4'h6;
  localparam logic [CMD_W-1:0] CMD_READ_BYTE     = 4'h7;
  localparam logic [CMD_W-1:0] CMD_WRITE_BYTE    = 4'h8;

  // ==========================================================================
  // CPU mode as seen by the debug controller
  // ==========================================================================
  typedef enum logic [2:0] {
    MODE_RUN    = 3'b001,  // User program running
    MODE_WAITST = 3'b010,  // CPU in wait or stop
    MODE_ACTIVE = 3'b100   // Active halt mode, awaiting commands
  } bdr_mode_t;

endpackage : bdr_pkg

//--- tb/bdr_debug_regs_assertions.sv
// Checker: port-level assertions for the debug register block
`timescale 1ns/1ps
module bdr_regs_chk
  import bdr_pkg::*;
#(parameter logic [15:0] FORCE_RESET_ADDR = 16'h1800)(
  // Clock, reset, command and answer
  input wire logic        clk, nrst, cmdValid, rspValid,
  input wire logic [3:0]  cmdCode,
  input wire logic [15:0] cmdAddr, cmdData, rspData,
  // Memory strobes and CPU side
  input wire logic        memRead, memWrite, cpuWaitStop, instrBoundary, tagAtQueueEnd,
  input wire logic        haltCpu, commClockSelect, resetRequest
);
  // ==========================================================
  // Defaults and sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // CPU awake for two samples, so memory commands are not refused
  sequence s_awake; !cpuWaitStop && !$past(cpuWaitStop); endsequence
  sequence s_fwr; cmdValid && cmdCode == CMD_WRITE_BYTE && cmdAddr == FORCE_RESET_ADDR && cmdData[0]; endsequence
  // Breakpoint word written, then read back two cycles on
  sequence s_bk; cmdValid && cmdCode == CMD_BREAKPOINT_WRITE_CMD ##2 cmdValid && cmdCode == CMD_BREAKPOINT_READ_CMD; endsequence
  // ==========================================================
  // Properties
  property p_frst; s_fwr ##0 s_awake |=> resetRequest; endproperty
  a_frst: assert property (p_frst) else $error("force reset write gave no request");
  property p_rsrc; resetRequest |-> $past(cmdValid && cmdCode == CMD_WRITE_BYTE && cmdData[0]); endproperty
  a_rsrc: assert property (p_rsrc) else $error("reset request without serial write");
  property p_stat;
    cmdValid && cmdCode == CMD_READ_STATUS |=> rspValid && rspData[15:8] == 8'h00 && !rspData[0]
      && rspData[6] == $past(haltCpu) && rspData[3] == $past(commClockSelect);
  endproperty
  a_stat: assert property (p_stat) else $error("status answer wrong");
  property p_bk; s_bk |=> rspValid && rspData == $past(cmdData, 3); endproperty
  a_bk: assert property (p_bk) else $error("breakpoint word not kept");
  property p_frd;
    cmdValid && cmdCode == CMD_READ_BYTE && cmdAddr == FORCE_RESET_ADDR ##0 s_awake |=> rspValid && rspData == READ_ZERO;
  endproperty
  a_frd: assert property (p_frd) else $error("force reset read not zero");
  property p_clk; cmdValid && cmdCode == CMD_WRITE_CONTROL |=> commClockSelect == $past(cmdData[3]); endproperty
  a_clk: assert property (p_clk) else $error("clock select not written");
  property p_wsr;
    cmdValid && (cmdCode == CMD_READ_BYTE || cmdCode == CMD_WRITE_BYTE) && cpuWaitStop && $past(cpuWaitStop)
      && !haltCpu && !$past(haltCpu) |=> !memRead && !memWrite && !rspValid;
  endproperty
  a_wsr: assert property (p_wsr) else $error("memory access in wait/stop");
  property p_halt;
    $rose(haltCpu) |-> $past(cmdValid && cmdCode == CMD_BACKGROUND) || $past(instrBoundary, 2)
      || $past(instrBoundary, 3) || $past(tagAtQueueEnd, 2) || $past(tagAtQueueEnd, 3);
  endproperty
  a_halt: assert property (p_halt) else $error("halt without a cause");
endmodule : bdr_regs_chk
bind bdr_debug_regs bdr_regs_chk #(.FORCE_RESET_ADDR(FORCE_RESET_ADDR)) u_chk (.clk(clk), .nrst(nrst),
  .cmdValid(cmdValid), .rspValid(rspValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdData(cmdData),
  .rspData(rspData), .memRead(memRead), .memWrite(memWrite), .cpuWaitStop(cpuWaitStop),
  .instrBoundary(instrBoundary), .tagAtQueueEnd(tagAtQueueEnd), .haltCpu(haltCpu),
  .commClockSelect(commClockSelect), .resetRequest(resetRequest));

//--- tb/bdr_debug_regs_test.sv
// Testbench: self-checking run of the debug register block
`timescale 1ns/1ps
module bdr_debug_regs_test;
  import bdr_pkg::*;
  // ==========================================================
  // Signals
  logic        clk, nrst, cmdValid, rspValid, memRead, memWrite, cpuWaitStop, cpuAddrValid, tg, sw;
  logic        instrBoundary, tagAtQueueEnd, haltCpu, tagOpcode, swiRequest, commClockSelect, resetRequest;
  logic [3:0]  cmdCode;
  logic [15:0] cmdAddr, cmdData, rspData, memAddr, cpuAddr, bk, d, r;
  logic [7:0]  memWData, memRData, ctl;  // ctl: expected control bits
  int          error_cnt, n_compared;
  localparam logic [15:0] FRA = 16'h1800;
  bdr_debug_regs #(.FORCE_RESET_ADDR(FRA)) dut (.clk(clk), .nrst(nrst), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
    .memRead(memRead), .memWrite(memWrite), .memAddr(memAddr), .memWData(memWData), .memRData(memRData),
    .cpuWaitStop(cpuWaitStop), .cpuAddr(cpuAddr), .cpuAddrValid(cpuAddrValid), .instrBoundary(instrBoundary),
    .tagAtQueueEnd(tagAtQueueEnd), .haltCpu(haltCpu), .tagOpcode(tagOpcode), .swiRequest(swiRequest),
    .commClockSelect(commClockSelect), .resetRequest(resetRequest));
  bdr_mem_model mem (.clk(clk), .memRead(memRead), .memWrite(memWrite), .memAddr(memAddr),
    .memWData(memWData), .memRData(memRData));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // One command, taken at the rising edge between two falling edges
  task automatic cmd(logic [3:0] c, logic [15:0] a = 16'h0000, logic [15:0] v = 16'h0000);
    @(negedge clk);
    {cmdValid, cmdCode, cmdAddr, cmdData} = {1'b1, c, a, v};
    @(negedge clk);
    cmdValid = 1'b0;
  endtask : cmd
  // Command with an answer; x if none within three cycles
  task automatic rd(logic [3:0] c, logic [15:0] a, output logic [15:0] v);
    cmd(c, a);
    v = 'x;
    repeat (3) begin
      if (rspValid === 1'b1) begin
        v = rspData;
        break;
      end
      @(negedge clk);
    end
  endtask : rd
  function automatic logic [15:0] stx(logic act, logic ws, logic wait_stop_failure_flag);
    return {8'h00, ctl[7], act, ctl[5:3], ws, wait_stop_failure_flag, 1'b0};
  endfunction : stx
  task automatic st(string nm, logic act, logic ws, logic wait_stop_failure_flag);
    rd(CMD_READ_STATUS, 16'h0000, r);
    chk(nm, r, stx(act, ws, wait_stop_failure_flag));
  endtask : st
  // Address match on the breakpoint, then a boundary or queue-end pulse
  task automatic hit(logic q);
    @(negedge clk);
    {cpuAddr, cpuAddrValid} = {bk, 1'b1};
    @(negedge clk);
    {tg, sw, cpuAddrValid, instrBoundary, tagAtQueueEnd} = {tagOpcode, 2'b00, !q, q};
    repeat (4) begin
      @(negedge clk);
      {instrBoundary, tagAtQueueEnd} = 2'b00;
      sw = sw | swiRequest;
    end
  endtask : hit
  // ==========================================================
  // Main sequence
  initial begin
    {nrst, cmdValid, cpuWaitStop, cpuAddrValid, instrBoundary, tagAtQueueEnd} = '0;
    {cmdCode, cmdAddr, cmdData, cpuAddr, ctl, bk} = '0;
    {error_cnt, n_compared} = '0;
    void'($urandom(32'h81BA));
    repeat (12) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    st("reset status", 0, 0, 0);
    r = 16'($urandom);
    cmd(CMD_WRITE_CONTROL, 16'h0000, {8'h00, r[7:0] | 8'h80});
    ctl = (r[7:0] | 8'h80) & 8'hB8;
    st("control write", 0, 0, 0);
    chk("clock select", 16'(commClockSelect), 16'(ctl[3]));
    cmd(CMD_BACKGROUND);
    chk("halt", 16'(haltCpu), 16'h0001);
    cmd(CMD_WRITE_CONTROL, 16'h0000, 16'h0000);
    ctl = 8'h80;
    st("enable locked", 1, 0, 0);
    bk = 16'($urandom);
    cmd(CMD_BREAKPOINT_WRITE_CMD, 16'h0000, bk);
    rd(CMD_BREAKPOINT_READ_CMD, 16'h0000, r);
    chk("breakpoint word", r, bk);
    $display("test control done");
    for (int i = 0; i < 4; i++) begin
      d = {8'h00, 8'($urandom)};
      cmd(CMD_WRITE_BYTE, 16'h2000 + 16'(i), d);
      rd(CMD_READ_BYTE, 16'h2000 + 16'(i), r);
      chk("memory byte", r, d);
    end
    rd(CMD_READ_BYTE, FRA, r);
    chk("force reset read", r, 16'h0000);
    cmd(CMD_WRITE_BYTE, FRA, 16'h0001);
    chk("reset pulse", 16'(resetRequest), 16'h0001);
    @(negedge clk);
    chk("reset pulse end", 16'(resetRequest), 16'h0000);
    $display("test memory done");
    for (int k = 0; k < 3; k++) begin
      ctl = (k == 0) ? 8'h90 : (k == 1) ? 8'hB0 : 8'hA0;
      cmd(CMD_WRITE_CONTROL, 16'h0000, {8'h00, ctl});
      if (haltCpu === 1'b1)
        cmd(CMD_GO);
      hit(k == 2);
      chk("tag mark", 16'(tg), 16'(k == 2));
      chk("break halt", 16'(haltCpu), 16'(k != 0));
    end
    $display("test breakpoint done");
    cmd(CMD_GO);
    cpuWaitStop = 1'b1;
    st("wait status", 0, 1, 0);
    cmd(CMD_READ_BYTE, 16'h2003);
    st("wait failure", 0, 1, 1);
    cmd(CMD_BACKGROUND);
    st("woken halt", 1, 1, 1);
    cpuWaitStop = 1'b0;
    rd(CMD_READ_BYTE, 16'h2003, r);
    chk("retried read", r, d);
    $display("test wait done");
    @(negedge clk) nrst = 1'b0;
    @(negedge clk) nrst = 1'b1;
    ctl = 8'h00;
    st("second reset", 0, 0, 0);
    cmd(CMD_BACKGROUND);
    chk("no halt", 16'(haltCpu), 16'h0000);
    ctl = 8'h30;
    cmd(CMD_WRITE_CONTROL, 16'h0000, 16'h0030);
    cmd(CMD_BREAKPOINT_WRITE_CMD, 16'h0000, bk);
    hit(1'b0);
    chk("soft interrupt", 16'(sw), 16'h0001);
    chk("swi no halt", 16'(haltCpu), 16'h0000);
    $display("test interrupt done");
    end_sim();
  end
  // Watchdog, about twenty-five times the expected run
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule : bdr_debug_regs_test

//--- tb/bdr_mem_model.sv
// Partner: debug memory behind the block's memory access port
`timescale 1ns/1ps
module bdr_mem_model (
  // Clock and access port
  input wire logic        clk, memRead, memWrite,
  input wire logic [15:0] memAddr,
  input wire logic [7:0]  memWData,
  output logic     [7:0]  memRData
);
  logic [7:0] store [16];    // Addressed by the low nibble only
  logic [7:0] idle = 8'h5A;  // Filler that moves, so a late sample never matches by luck
  // Writes land on the strobe edge
  always @(posedge clk) begin
    idle <= idle + 8'h3B;
    if (memWrite)
      store[memAddr[3:0]] <= memWData;
  end
  assign memRData = memRead ? store[memAddr[3:0]] : idle;
endmodule : bdr_mem_model
